// ---- rtl/fsmp_top.v ----
// four mode serial port: apb registers, transmitter, receiver, pin muxing
// assumes pins are synchronous to pclk and software presets the gpio side
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "fsmp_map.vh"
module fsmp_top (
  input wire pclk, // system clock, 10 mhz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error
  input wire timer_ovf, // secondary timer overflow pulse
  input wire serial_rx_pin_in, // rx pin level
  output reg serial_rx_pin_out, // rx pin drive value
  output reg serial_rx_pin_oe_n, // rx pin enable, low drives
  output reg serial_tx_pin_out, // tx pin drive value
  output reg serial_tx_pin_oe_n, // tx pin enable, low drives
  input wire gpio_rx_out, // gpio value for rx pin
  input wire gpio_rx_oe_n, // gpio enable for rx pin
  input wire gpio_tx_out, // gpio value for tx pin
  input wire gpio_tx_oe_n, // gpio enable for tx pin
  output reg serial_irq // gated interrupt request
);
localparam TX_IDLE = 2'h0;
localparam TX_ASYNC = 2'h1;
localparam TX_SYNC = 2'h2;
reg [1:0] mode_ff;
reg mpe_ff;
reg rx_en_ff;
reg tb8_ff;
reg rb8_ff;
reg ti_ff;
reg ri_ff;
reg bsel_ff;
reg dbl_ff;
reg od_ff;
reg ie_ff;
reg [9:0] reload_ff;
reg [7:0] rx_buf_ff;
reg [1:0] tx_st_ff;
reg [10:0] tx_shift_ff;
reg [3:0] tx_sub_ff;
reg [3:0] tx_cnt_ff;
reg tx_line_ff;
reg m0_clk_ff;
reg m0_rx_ff;
reg [7:0] m0_in_ff;
reg rx_busy_ff;
reg [3:0] rx_sub_ff;
reg [3:0] rx_cnt_ff;
reg [8:0] rx_shift_ff;
reg rx_prev_ff;
wire tick16;
wire tick_half;
// asynchronous modes with a ninth data bit
function is_nine;
  input [1:0] m;
  begin
    is_nine = m[1];
  end
endfunction
// push-pull or open-drain drive of one pin, {out, oe_n}
function [1:0] pin_drive;
  input val;
  input od;
  begin
    if (od) begin
      pin_drive = {1'b0, val};
    end else begin
      pin_drive = {val, 1'b0};
    end
  end
endfunction
fsmp_baud u_baud (
  .pclk(pclk),
  .presetn(presetn),
  .run(rx_en_ff),
  .mode(mode_ff),
  .baud_double(dbl_ff),
  .baud_source_select(bsel_ff),
  .reload(reload_ff),
  .timer_ovf(timer_ovf),
  .tick16_ff(tick16),
  .tick_half_ff(tick_half)
);
////////////////////////////////////////////////////////////////////////////////
// apb decode; answer is always one cycle after the setup phase
wire setup = psel & ~penable;
wire wr_en = psel & penable & pready & pwrite & ~pslverr;
wire sel_ctrl = (paddr == `FSMP_ADDR_CTRL);
wire sel_cfg = (paddr == `FSMP_ADDR_CFG);
wire sel_data = (paddr == `FSMP_ADDR_DATA);
wire sel_rel = (paddr == `FSMP_ADDR_RELOAD);
// everything but the control register is locked while the port is halted
wire bad_addr = ~(sel_ctrl | ((sel_cfg | sel_data | sel_rel) & rx_en_ff));
wire wr_ctrl = wr_en & sel_ctrl;
wire wr_data = wr_en & sel_data;
wire [7:0] ctrl_rd = {mode_ff, mpe_ff, rx_en_ff, tb8_ff, rb8_ff, ti_ff, ri_ff};
reg [31:0] nxt_prdata;
always @* begin
  nxt_prdata = 32'h0000_0000;
  if (sel_ctrl) begin
    nxt_prdata = {24'h00_0000, ctrl_rd};
  end else if (bad_addr) begin
    nxt_prdata = 32'h0000_0000;
  end else if (sel_cfg) begin
    nxt_prdata = {28'h000_0000, ie_ff, od_ff, dbl_ff, bsel_ff};
  end else if (sel_data) begin
    nxt_prdata = {24'h00_0000, rx_buf_ff};
  end else if (sel_rel) begin
    nxt_prdata = {22'h00_0000, reload_ff};
  end
end
// read data and status are latched in setup so they come from flops
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h0000_0000;
    pready <= 1'b0;
    pslverr <= 1'b0;
  end else begin
    pready <= setup;
    pslverr <= setup & bad_addr;
    if (setup) begin
      prdata <= nxt_prdata;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// configuration registers
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    mode_ff <= `FSMP_MODE0;
    mpe_ff <= 1'b0;
    rx_en_ff <= 1'b0;
    tb8_ff <= 1'b0;
    {ie_ff, od_ff, dbl_ff, bsel_ff} <= `FSMP_CFG_RST;
    reload_ff <= `FSMP_RELOAD_RST;
  end else begin
    if (wr_ctrl) begin
      mode_ff <= {pwdata[`FSMP_CTRL_MODE_HI], pwdata[`FSMP_CTRL_MODE_LO]};
      mpe_ff <= pwdata[`FSMP_CTRL_MPE];
      rx_en_ff <= pwdata[`FSMP_CTRL_RXEN];
      tb8_ff <= pwdata[`FSMP_CTRL_TB8];
    end
    if (wr_en & sel_cfg) begin
      bsel_ff <= pwdata[`FSMP_CFG_BSEL];
      dbl_ff <= pwdata[`FSMP_CFG_DBL];
      od_ff <= pwdata[`FSMP_CFG_OD];
      ie_ff <= pwdata[`FSMP_CFG_IE];
    end
    if (wr_en & sel_rel) begin
      reload_ff <= pwdata[9:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// transmitter and mode 0 shift engine
// mode 0 receive reuses this engine since it owns the shift clock
wire m0_rx_go = (mode_ff == `FSMP_MODE0) & rx_en_ff & ~ri_ff & ~wr_data;
wire [3:0] tx_bits = is_nine(mode_ff) ? 4'hb : 4'ha;
reg set_ti;
reg set_ri_m0;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    tx_st_ff <= TX_IDLE;
    tx_shift_ff <= 11'h7ff;
    tx_sub_ff <= 4'h0;
    tx_cnt_ff <= 4'h0;
    tx_line_ff <= 1'b1;
    m0_clk_ff <= 1'b1;
    m0_rx_ff <= 1'b0;
    m0_in_ff <= 8'h00;
    set_ti <= 1'b0;
    set_ri_m0 <= 1'b0;
  end else begin
    set_ti <= 1'b0;
    set_ri_m0 <= 1'b0;
    if (!rx_en_ff) begin
      tx_st_ff <= TX_IDLE;
      tx_line_ff <= 1'b1;
      m0_clk_ff <= 1'b1;
    end else begin
      case (tx_st_ff)
        TX_IDLE: begin
          tx_sub_ff <= 4'h0;
          tx_cnt_ff <= 4'h0;
          m0_clk_ff <= 1'b1;
          if (wr_data) begin
            // frame: start, data lsb first, ninth or stop, stop
            tx_shift_ff <= {1'b1, is_nine(mode_ff) ? tb8_ff : 1'b1, pwdata[7:0], 1'b0};
            tx_line_ff <= (mode_ff == `FSMP_MODE0) ? pwdata[0] : 1'b0;
            m0_rx_ff <= 1'b0;
            tx_st_ff <= (mode_ff == `FSMP_MODE0) ? TX_SYNC : TX_ASYNC;
            if (mode_ff == `FSMP_MODE0) begin
              tx_shift_ff <= {3'h7, pwdata[7:0]};
            end
          end else if (m0_rx_go) begin
            m0_rx_ff <= 1'b1;
            tx_line_ff <= 1'b1;
            tx_st_ff <= TX_SYNC;
          end
        end
        TX_ASYNC: begin
          if (tick16) begin
            tx_sub_ff <= tx_sub_ff + 4'h1;
            if (tx_sub_ff == `FSMP_SUB_END) begin
              tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
              tx_line_ff <= tx_shift_ff[1];
              tx_cnt_ff <= tx_cnt_ff + 4'h1;
              if (tx_cnt_ff + 4'h1 == tx_bits - 4'h1) begin
                set_ti <= 1'b1;
              end
              if (tx_cnt_ff + 4'h1 == tx_bits) begin
                tx_st_ff <= TX_IDLE;
              end
            end
          end
        end
        TX_SYNC: begin
          if (tick_half) begin
            m0_clk_ff <= ~m0_clk_ff;
            if (m0_clk_ff) begin
              // falling edge: next data bit out
              if (tx_cnt_ff != 4'h0 && !m0_rx_ff) begin
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_line_ff <= tx_shift_ff[1];
              end
            end else begin
              // rising edge: the peripheral and this receiver sample
              if (m0_rx_ff) begin
                m0_in_ff <= {serial_rx_pin_in, m0_in_ff[7:1]};
              end
              tx_cnt_ff <= tx_cnt_ff + 4'h1;
              if (tx_cnt_ff == 4'h7) begin
                tx_st_ff <= TX_IDLE;
                set_ti <= ~m0_rx_ff;
                set_ri_m0 <= m0_rx_ff;
              end
            end
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// asynchronous receiver, centre sampling on the 16x tick
// a start that is high again at mid bit is taken as a glitch and dropped
wire async_mode = (mode_ff != `FSMP_MODE0);
wire [3:0] rx_data_bits = is_nine(mode_ff) ? 4'h9 : 4'h8;
reg set_ri_async;
reg [7:0] rx_word;
reg rx_ninth;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    rx_busy_ff <= 1'b0;
    rx_sub_ff <= 4'h0;
    rx_cnt_ff <= 4'h0;
    rx_shift_ff <= 9'h000;
    rx_prev_ff <= 1'b1;
    set_ri_async <= 1'b0;
    rx_word <= 8'h00;
    rx_ninth <= 1'b0;
  end else begin
    set_ri_async <= 1'b0;
    rx_prev_ff <= serial_rx_pin_in;
    if (!rx_en_ff || !async_mode) begin
      rx_busy_ff <= 1'b0;
    end else if (!rx_busy_ff) begin
      rx_sub_ff <= 4'h0;
      rx_cnt_ff <= 4'h0;
      if (rx_prev_ff & ~serial_rx_pin_in) begin
        rx_busy_ff <= 1'b1;
      end
    end else if (tick16) begin
      rx_sub_ff <= rx_sub_ff + 4'h1;
      if (rx_sub_ff == `FSMP_SUB_MID) begin
        rx_cnt_ff <= rx_cnt_ff + 4'h1;
        if (rx_cnt_ff == 4'h0) begin
          rx_busy_ff <= ~serial_rx_pin_in;
        end else if (rx_cnt_ff <= rx_data_bits) begin
          rx_shift_ff <= {serial_rx_pin_in, rx_shift_ff[8:1]};
        end else begin
          // mid stop bit: frame complete
          rx_busy_ff <= 1'b0;
          rx_word <= is_nine(mode_ff) ? rx_shift_ff[7:0] : rx_shift_ff[8:1];
          rx_ninth <= is_nine(mode_ff) ? rx_shift_ff[8] : serial_rx_pin_in;
          // ninth or stop bit zero is ignored in multiprocessor mode
          set_ri_async <= ~mpe_ff | (is_nine(mode_ff) ? rx_shift_ff[8] : serial_rx_pin_in);
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// receive buffer, ninth bit and sticky done flags; a set beats a clear
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    rx_buf_ff <= 8'h00;
    rb8_ff <= 1'b0;
    ti_ff <= 1'b0;
    ri_ff <= 1'b0;
  end else begin
    if (wr_ctrl) begin
      ti_ff <= pwdata[`FSMP_CTRL_TI] | set_ti;
      ri_ff <= pwdata[`FSMP_CTRL_RI] | set_ri_m0 | set_ri_async;
      rb8_ff <= pwdata[`FSMP_CTRL_RB8];
    end else begin
      ti_ff <= ti_ff | set_ti;
      ri_ff <= ri_ff | set_ri_m0 | set_ri_async;
    end
    if (set_ri_m0) begin
      rx_buf_ff <= m0_in_ff;
    end
    if (set_ri_async) begin
      rx_buf_ff <= rx_word;
      rb8_ff <= rx_ninth;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// pins and interrupt; when halted the gpio side owns the pins again
reg [1:0] nxt_tx_pin;
reg [1:0] nxt_rx_pin;
always @* begin
  nxt_tx_pin = {gpio_tx_out, gpio_tx_oe_n};
  nxt_rx_pin = {gpio_rx_out, gpio_rx_oe_n};
  if (rx_en_ff) begin
    if (mode_ff == `FSMP_MODE0) begin
      nxt_tx_pin = pin_drive(m0_clk_ff, od_ff);
      if (tx_st_ff == TX_SYNC && m0_rx_ff) begin
        nxt_rx_pin = 2'b01;
      end else begin
        nxt_rx_pin = pin_drive(tx_line_ff, od_ff);
      end
    end else begin
      nxt_tx_pin = pin_drive(tx_line_ff, od_ff);
      nxt_rx_pin = 2'b01;
    end
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    serial_tx_pin_out <= 1'b0;
    serial_tx_pin_oe_n <= 1'b1;
    serial_rx_pin_out <= 1'b0;
    serial_rx_pin_oe_n <= 1'b1;
    serial_irq <= 1'b0;
  end else begin
    {serial_tx_pin_out, serial_tx_pin_oe_n} <= nxt_tx_pin;
    {serial_rx_pin_out, serial_rx_pin_oe_n} <= nxt_rx_pin;
    serial_irq <= ie_ff & (ti_ff | ri_ff);
  end
end
endmodule

// ---- rtl/fsmp_map.vh ----
// constants for the four mode serial port: register map, field positions, dividers
// assumes a 10 mhz pclk and an apb master with 32-bit data
`ifndef FSMP_MAP_VH
`define FSMP_MAP_VH
// byte addresses
`define FSMP_ADDR_CTRL 12'h000
`define FSMP_ADDR_CFG 12'h004
`define FSMP_ADDR_DATA 12'h008
`define FSMP_ADDR_RELOAD 12'h00c
// control register fields
`define FSMP_CTRL_MODE_HI 7
`define FSMP_CTRL_MODE_LO 6
`define FSMP_CTRL_MPE 5
`define FSMP_CTRL_RXEN 4
`define FSMP_CTRL_TB8 3
`define FSMP_CTRL_RB8 2
`define FSMP_CTRL_TI 1
`define FSMP_CTRL_RI 0
// config register fields
`define FSMP_CFG_BSEL 0
`define FSMP_CFG_DBL 1
`define FSMP_CFG_OD 2
`define FSMP_CFG_IE 3
// reset values
`define FSMP_CTRL_RST 8'h00
`define FSMP_CFG_RST 4'h0
`define FSMP_RELOAD_RST 10'h000
// modes
`define FSMP_MODE0 2'h0
`define FSMP_MODE1 2'h1
`define FSMP_MODE2 2'h2
`define FSMP_MODE3 2'h3
// dividers in pclk cycles; the sub-bit positions in 16x ticks
`define FSMP_M0_HALF 4'h6
`define FSMP_PRE_NORM 3'h4
`define FSMP_PRE_DBL 3'h2
`define FSMP_SUB_MID 4'h7
`define FSMP_SUB_END 4'hf
`endif

// ---- rtl/fsmp_baud.v ----
// baud tick generator for the four mode serial port
// assumes timer_ovf is a one-cycle pulse from the secondary timer
`timescale 1ns/1ns
`include "fsmp_map.vh"
module fsmp_baud (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire run, // port enabled, else counters held
  input wire [1:0] mode, // operating mode
  input wire baud_double, // double the rate in modes 1 to 3
  input wire baud_source_select, // 0 timer, 1 reload generator
  input wire [9:0] reload, // reload value
  input wire timer_ovf, // secondary timer overflow pulse
  output reg tick16_ff, // 16x bit rate pulse
  output reg tick_half_ff // mode 0 half bit pulse
);

reg [2:0] pre_ff;
reg [9:0] gen_ff;
reg [3:0] m0_ff;
reg t1_div_ff;
wire pre_end = (pre_ff == (baud_double ? `FSMP_PRE_DBL : `FSMP_PRE_NORM) - 3'h1);
wire gen_end = (gen_ff == 10'h3ff);

////////////////////////////////////////////////////////////////////////////////
// prescaler, reload counter and timer divider; stopped when the port is off
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pre_ff <= 3'h0;
    gen_ff <= 10'h000;
    m0_ff <= 4'h0;
    t1_div_ff <= 1'b0;
    tick16_ff <= 1'b0;
    tick_half_ff <= 1'b0;
  end else if (!run) begin
    pre_ff <= 3'h0;
    gen_ff <= reload;
    m0_ff <= 4'h0;
    t1_div_ff <= 1'b0;
    tick16_ff <= 1'b0;
    tick_half_ff <= 1'b0;
  end else begin
    // mode 0: fixed fcpu/12, two half-bit ticks per bit
    tick_half_ff <= (m0_ff == `FSMP_M0_HALF - 4'h1);
    m0_ff <= (m0_ff == `FSMP_M0_HALF - 4'h1) ? 4'h0 : m0_ff + 4'h1;
    pre_ff <= pre_end ? 3'h0 : pre_ff + 3'h1;
    if (pre_end) begin
      gen_ff <= gen_end ? reload : gen_ff + 10'h001;
    end
    if (timer_ovf) begin
      t1_div_ff <= ~t1_div_ff;
    end
    case (mode)
      `FSMP_MODE2: tick16_ff <= pre_end;
      `FSMP_MODE1, `FSMP_MODE3: begin
        if (baud_source_select) begin
          tick16_ff <= pre_end & gen_end;
        end else begin
          // ovf/32 per bit, so one 16x tick per two overflows unless doubled
          tick16_ff <= timer_ovf & (baud_double | t1_div_ff);
        end
      end
      default: tick16_ff <= 1'b0;
    endcase
  end
end

endmodule

// ---- test/fsmp_monitor.sv ----
// checker for the four mode serial port, bound to fsmp_top
// assumes the offsets of the map header and pins registered on pclk
`timescale 1ns/1ns
`include "fsmp_map.vh"
module fsmp_monitor (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // apb select
  input wire penable, // apb access
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb write data
  input wire [31:0] prdata, // apb read data
  input wire pready, // apb ready
  input wire pslverr, // apb error
  input wire serial_rx_pin_out, // rx drive
  input wire serial_rx_pin_oe_n, // rx enable
  input wire serial_tx_pin_out, // tx drive
  input wire serial_tx_pin_oe_n, // tx enable
  input wire gpio_rx_out, // gpio rx value
  input wire gpio_rx_oe_n, // gpio rx enable
  input wire gpio_tx_out, // gpio tx value
  input wire gpio_tx_oe_n, // gpio tx enable
  input wire serial_irq // interrupt
);
  reg en_ff;
  reg ie_ff;
  reg up_ff;
  wire acc = psel & penable & pready;
  wire wr_ok = acc & pwrite & ~pslverr;
  wire [3:0] pins = {serial_tx_pin_out, serial_tx_pin_oe_n, serial_rx_pin_out, serial_rx_pin_oe_n};
  wire [3:0] gpio = {gpio_tx_out, gpio_tx_oe_n, gpio_rx_out, gpio_rx_oe_n};
  ////////////////////////////////////////////////////////////////
  // shadows of the enables; refused writes must not move them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 1'b0;
      ie_ff <= 1'b0;
      up_ff <= 1'b0;
    end else begin
      up_ff <= 1'b1;
      if (wr_ok && paddr == `FSMP_ADDR_CTRL) en_ff <= pwdata[`FSMP_CTRL_RXEN];
      if (wr_ok && paddr == `FSMP_ADDR_CFG) ie_ff <= pwdata[`FSMP_CFG_IE];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  rdy_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  locked_refuse_a: assert property (acc && !en_ff && paddr != 12'h000 |-> pslverr)
    else $error("locked register answered");
  open_access_a: assert property (acc && en_ff && paddr <= 12'h00c && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("mapped register refused");
  unmapped_refuse_a: assert property (acc && paddr > 12'h00c |-> pslverr)
    else $error("unmapped address answered");
  err_reads_zero_a: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  pins_to_gpio_a: assert property (up_ff && !en_ff && !$past(en_ff) |-> pins == $past(gpio))
    else $error("pins not handed to gpio");
  irq_gated_off_a: assert property (!ie_ff && !$past(ie_ff) |-> !serial_irq)
    else $error("interrupt while disabled");
  cover property (acc && pslverr);
  cover property (serial_irq);
  cover property (!en_ff ##1 en_ff);
endmodule
bind fsmp_top fsmp_monitor mon_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .serial_rx_pin_out, .serial_rx_pin_oe_n, .serial_tx_pin_out, .serial_tx_pin_oe_n,
  .gpio_rx_out, .gpio_rx_oe_n, .gpio_tx_out, .gpio_tx_oe_n, .serial_irq
);

// ---- test/fsmp_peer.sv ----
// far-side serial device: async frames and mode 0 shift partner
// assumes the bench resolves both pins with pull-ups
`timescale 1ns/1ns
module fsmp_peer (
  input wire pclk, // clock
  input wire tx_line, // tx pin level
  input wire rx_line, // rx pin level
  output reg drive // rx pin drive, 1 = released
);
  initial drive = 1'b1;
  // start bit, nb bits lsb first, then released high for a stop
  task send(input [8:0] d, input int nb, input int bc);
    int i;
    begin
      drive <= 1'b0;
      repeat (bc) @(posedge pclk);
      for (i = 0; i < nb; i = i + 1) begin
        drive <= d[i];
        repeat (bc) @(posedge pclk);
      end
      drive <= 1'b1;
      repeat (bc) @(posedge pclk);
    end
  endtask
  // samples mid-bit, timed from the start edge
  task recv(output [8:0] d, input int nb, input int bc);
    int i;
    begin
      d = 9'h000;
      @(negedge tx_line);
      repeat (bc / 2) @(posedge pclk);
      for (i = 0; i < nb; i = i + 1) begin
        repeat (bc) @(posedge pclk);
        d[i] = tx_line;
      end
    end
  endtask
  // shift register: data taken at rising shift clock
  task shift_in(output [7:0] d);
    int i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge tx_line);
        d[i] = rx_line;
      end
    end
  endtask
  // data changes at falling shift clock, held past the last rise
  task shift_out(input [7:0] d);
    int i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(negedge tx_line);
        drive <= d[i];
      end
      @(posedge tx_line);
      repeat (3) @(posedge pclk);
      drive <= 1'b1;
    end
  endtask
endmodule

// ---- test/tb_four_mode_serial_port.sv ----
// self-checking bench for the four mode serial port
// assumes fsmp_top, its map header, the peer model and a 10 mhz pclk
`timescale 1ns/1ns
`include "fsmp_map.vh"
module tb_four_mode_serial_port;
  localparam [11:0] a_ctl = `FSMP_ADDR_CTRL;
  localparam [11:0] a_cfg = `FSMP_ADDR_CFG;
  localparam [11:0] a_dat = `FSMP_ADDR_DATA;
  localparam [11:0] a_rld = `FSMP_ADDR_RELOAD;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg tmr_en = 1'b0;
  reg timer_ovf = 1'b0;
  reg gtx = 1'b1;
  reg [31:0] rdat;
  reg rerr;
  reg [8:0] f;
  int n_mismatch = 0;
  int compares = 0;
  wire [31:0] prdata;
  wire pready, pslverr, serial_irq, rx_o, rx_oe_n, tx_o, tx_oe_n, pdrv;
  // released lines float high on the pull-ups
  wire tx_lvl = tx_oe_n ? 1'b1 : tx_o;
  wire rx_lvl = rx_oe_n ? pdrv : (rx_o & pdrv);
  always #50 pclk = ~pclk;
  // timer overflow every second cycle while running
  always @(posedge pclk) timer_ovf <= tmr_en & ~timer_ovf;
  // gpio side: tx output from gtx, high until the disable test, rx input
  fsmp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_ovf(timer_ovf), .serial_rx_pin_in(rx_lvl),
    .serial_rx_pin_out(rx_o), .serial_rx_pin_oe_n(rx_oe_n), .serial_tx_pin_out(tx_o),
    .serial_tx_pin_oe_n(tx_oe_n), .gpio_rx_out(1'b1), .gpio_rx_oe_n(1'b1),
    .gpio_tx_out(gtx), .gpio_tx_oe_n(1'b0), .serial_irq(serial_irq));
  fsmp_peer peer_u (.pclk(pclk), .tx_line(tx_lvl), .rx_line(rx_lvl), .drive(pdrv));
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one apb transfer; an idle edge after it keeps drives apart
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle limit here; the watchdog ends a hung transfer
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [11:0] a, input [31:0] e, input ee);
    begin
      apb(1'b0, a, 32'h0);
      chk("prdata", rdat, e);
      chk("pslverr", 32'(rerr), 32'(ee));
    end
  endtask
  task tdone(input string nm);
    $display("test %s done", nm);
  endtask
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #5000000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("pins", 32'({tx_o, tx_oe_n, rx_oe_n}), 32'h5);
    rdc(a_ctl, 32'h0, 1'b0);
    rdc(a_cfg, 32'h0, 1'b1);
    tdone("reset");
    wr(a_ctl, 32'h98);
    wr(a_cfg, 32'hc);
    rdc(a_cfg, 32'hc, 1'b0);
    rdc(12'h010, 32'h0, 1'b1);
    wr(a_dat, 32'ha5);
    peer_u.recv(f, 9, 64);
    chk("frame", 32'(f), 32'h1a5);
    repeat (40) @(posedge pclk);
    chk("irq", 32'(serial_irq), 32'h1);
    chk("od out", 32'(tx_o), 32'h0);
    rdc(a_ctl, 32'h9a, 1'b0);
    repeat (80) @(posedge pclk);
    tdone("mode2 tx");
    wr(a_ctl, 32'h90);
    wr(a_cfg, 32'h0);
    peer_u.send(9'h03c, 9, 64);
    chk("irq", 32'(serial_irq), 32'h0);
    rdc(a_ctl, 32'h91, 1'b0);
    rdc(a_dat, 32'h3c, 1'b0);
    wr(a_ctl, 32'hb0);
    peer_u.send(9'h011, 9, 64);
    rdc(a_ctl, 32'hb0, 1'b0);
    peer_u.send(9'h122, 9, 64);
    rdc(a_ctl, 32'hb5, 1'b0);
    rdc(a_dat, 32'h22, 1'b0);
    tdone("mode2 rx");
    wr(a_rld, 32'h3fe);
    wr(a_cfg, 32'h1);
    // the generator only reloads on wrap or halt, so halt once to load it now
    wr(a_ctl, 32'h40);
    wr(a_ctl, 32'h50);
    rdc(a_rld, 32'h3fe, 1'b0);
    wr(a_dat, 32'h5a);
    fork
      peer_u.recv(f, 9, 128);
      peer_u.send(9'h1c3, 9, 128);
    join
    chk("frame", 32'(f), 32'h15a);
    rdc(a_ctl, 32'h57, 1'b0);
    rdc(a_dat, 32'hc3, 1'b0);
    tdone("mode1 duplex");
    tmr_en <= 1'b1;
    wr(a_cfg, 32'h2);
    wr(a_ctl, 32'hd8);
    wr(a_dat, 32'h81);
    peer_u.recv(f, 9, 32);
    chk("frame", 32'(f), 32'h181);
    // let the stop bit finish before the mode changes under the transmitter
    repeat (80) @(posedge pclk);
    tdone("mode3 timer");
    wr(a_ctl, 32'h11);
    wr(a_dat, 32'h96);
    peer_u.shift_in(f[7:0]);
    chk("shift", 32'(f[7:0]), 32'h96);
    repeat (20) @(posedge pclk);
    rdc(a_ctl, 32'h13, 1'b0);
    wr(a_ctl, 32'h10);
    peer_u.shift_out(8'h6b);
    repeat (20) @(posedge pclk);
    rdc(a_ctl, 32'h11, 1'b0);
    rdc(a_dat, 32'h6b, 1'b0);
    tdone("mode0");
    gtx <= 1'b0;
    wr(a_ctl, 32'h0);
    repeat (3) @(posedge pclk);
    chk("pins", 32'({tx_o, tx_oe_n, rx_oe_n}), 32'h1);
    tdone("disable");
    report_and_stop;
  end
endmodule
